// [io_sample_rx_frame_builder.sv]
// Purpose: emits the received IO sample indication frame as a
//   byte stream toward the host-facing serial transmitter
// Assumes: sample fields are held stable while sampleValid is high
// Notes: valid/ready byte handshake on the output side
//
// Notes on behaviour
// - Frames go out only while the api output option equals 0.
// - Frames go out only in framed API mode, never transparent.
// - Bytes 1-2 hold length MSB first, type through last data byte.
// - Byte 3 is frame type 92.
// - Bytes 4-11 hold the sender long address, MSB first.
// - Bytes 12-13 hold the sender network address, MSB first.
// - Byte 14 options: 01 acknowledged, 02 broadcast.
// - Byte 15, sample set count, is always 1.
// - Bytes 16-17 are the digital channel mask.
// - Byte 18 is the analog channel mask.
// - Two digital sample bytes follow only if digital mask nonzero.
// - Digital sample bits of disabled lines read zero.
// - Digital sample bits map like the digital mask bits.
// - Each enabled analog channel adds a two-byte result.
// - Analog results ascend input 0 to 3, supply reading last.
// - Last byte is FF minus low byte of sum from offset 3.
`timescale 1ns/10ps
`default_nettype none
`include "io_sample_rx_regs.svh"
module io_sample_rx_frame_builder (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Mode straps
  input wire logic apiOutputOption,
  input wire logic apiFramedMode,
  // Decoded sample from the radio receive path
  input wire logic sampleValid,
  input wire logic [63:0] srcLongAddr,
  input wire logic [15:0] srcNetAddr,
  input wire logic wasAcked,
  input wire logic wasBroadcast,
  input wire logic [15:0] digitalMask,
  input wire logic [7:0] analogMask,
  input wire logic [15:0] digitalSamples,
  input wire logic [15:0] analogIn0,
  input wire logic [15:0] analogIn1,
  input wire logic [15:0] analogIn2,
  input wire logic [15:0] analogIn3,
  input wire logic [15:0] supplyVoltage,
  output logic sampleTaken,
  output logic sampleDropped,
  // Byte stream toward the serial transmitter
  output io_sample_rx_pkg::byte_t txData,
  output logic txValid,
  input wire logic txReady,
  output logic frameBusy
);
  import io_sample_rx_pkg::*;
  // Every assertion samples on the rising edge and sleeps in reset
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Captured frame content
  // ----------------------------------------------------------------
  emit_state_t state_reg;
  logic [63:0] longAddr_reg;
  logic [15:0] netAddr_reg;
  logic [7:0] options_reg;
  logic [15:0] dMask_reg;
  logic [7:0] aMask_reg;
  logic [15:0] dSamp_reg;
  logic [15:0] ana_reg [0:7];
  logic [15:0] length_reg;
  logic [7:0] pending_reg;
  logic [4:0] index_reg;
  logic lowHalf_reg;
  logic [7:0] checkSum;
  logic found;
  logic [2:0] chan;
  logic accept;
  logic step;
  logic clearSum;
  logic [15:0] dMaskIn;
  logic [7:0] aMaskIn;
  logic [3:0] anaCount;
  byte_t headByte;
  logic [15:0] sentCount_reg;
  logic [15:0] anaWord;

  // Only lines that exist may be flagged
  assign dMaskIn = digitalMask & `DMASK_VALID;
  assign aMaskIn = analogMask & `AMASK_VALID;
  assign anaCount = 4'(aMaskIn[0]) + 4'(aMaskIn[1]) + 4'(aMaskIn[2])
                  + 4'(aMaskIn[3]) + 4'(aMaskIn[7]);

  // Take a sample only in framed API mode with option 0
  assign accept = sampleValid && (state_reg == ST_IDLE)
                  && (apiOutputOption == `API_OPT_FRAMED)
                  && apiFramedMode;
  assign step = txValid && txReady;
  assign clearSum = accept;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  io_checksum_acc u_sum (
    .clock(clock),
    .rst_n(rst_n),
    .clear(clearSum),
    .add(step && (index_reg >= `OFS_TYPE) && (state_reg != ST_SUM)),
    .dataIn(txData),
    .checkSum(checkSum)
  );

  io_analog_pick u_pick (
    .pending(pending_reg),
    .found(found),
    .chan(chan)
  );

  // Capture the sample; the pending set tracks unsent analog words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      longAddr_reg <= 64'h0000000000000000;
      netAddr_reg <= 16'h0000;
      options_reg <= 8'h00;
      dMask_reg <= 16'h0000;
      aMask_reg <= 8'h00;
      dSamp_reg <= 16'h0000;
      length_reg <= 16'h0000;
    end else if (accept) begin
      longAddr_reg <= srcLongAddr;
      netAddr_reg <= srcNetAddr;
      // Broadcast wins if both are flagged, the radio cannot ack it
      options_reg <= wasBroadcast ? `OPT_BCAST
                   : (wasAcked ? `OPT_ACKED : 8'h00);
      dMask_reg <= dMaskIn;
      aMask_reg <= aMaskIn;
      dSamp_reg <= digitalSamples & dMaskIn;
      length_reg <= `FIXED_LEN + ((dMaskIn != 16'h0000) ? 16'h0002
                    : 16'h0000) + {11'h000, anaCount, 1'b0};
    end
  end

  // Analog words stored by channel index
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        ana_reg[i] <= 16'h0000;
      end
    end else if (accept) begin
      ana_reg[0] <= analogIn0;
      ana_reg[1] <= analogIn1;
      ana_reg[2] <= analogIn2;
      ana_reg[3] <= analogIn3;
      ana_reg[`AMASK_SUPPLY] <= supplyVoltage;
    end
  end

  // ----------------------------------------------------------------
  // Header byte selection
  // ----------------------------------------------------------------
  always_comb begin
    case (index_reg)
      5'd0: headByte = `START_DELIM;
      5'd1: headByte = length_reg[15:8];
      5'd2: headByte = length_reg[7:0];
      5'd3: headByte = `FRAME_TYPE_IO;
      5'd4: headByte = longAddr_reg[63:56];
      5'd5: headByte = longAddr_reg[55:48];
      5'd6: headByte = longAddr_reg[47:40];
      5'd7: headByte = longAddr_reg[39:32];
      5'd8: headByte = longAddr_reg[31:24];
      5'd9: headByte = longAddr_reg[23:16];
      5'd10: headByte = longAddr_reg[15:8];
      5'd11: headByte = longAddr_reg[7:0];
      5'd12: headByte = netAddr_reg[15:8];
      5'd13: headByte = netAddr_reg[7:0];
      5'd14: headByte = options_reg;
      5'd15: headByte = `SAMPLE_SETS;
      5'd16: headByte = dMask_reg[15:8];
      5'd17: headByte = dMask_reg[7:0];
      5'd18: headByte = aMask_reg;
      default: headByte = 8'h00;
    endcase
  end

  assign anaWord = ana_reg[chan];

  // Bytes moved from the type byte on, to cross-check the length field
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sentCount_reg <= 16'h0000;
    end else if (accept) begin
      sentCount_reg <= 16'h0000;
    end else if (step && (index_reg >= `OFS_TYPE)
                 && (state_reg != ST_SUM)) begin
      sentCount_reg <= sentCount_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Emitter state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      index_reg <= 5'h00;
      lowHalf_reg <= 1'b0;
      pending_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= ST_HEAD;
            index_reg <= 5'h00;
            lowHalf_reg <= 1'b0;
            pending_reg <= aMaskIn;
          end
        end
        ST_HEAD: begin
          if (step) begin
            index_reg <= index_reg + 5'h01;
            if (index_reg == `OFS_AMASK) begin
              // Digital field omitted for an empty mask
              if (dMask_reg != 16'h0000) begin
                state_reg <= ST_DIG;
              end else if (pending_reg != 8'h00) begin
                state_reg <= ST_ANA;
              end else begin
                state_reg <= ST_SUM;
              end
            end
          end
        end
        ST_DIG: begin
          if (step) begin
            lowHalf_reg <= ~lowHalf_reg;
            if (lowHalf_reg) begin
              lowHalf_reg <= 1'b0;
              state_reg <= (pending_reg != 8'h00) ? ST_ANA : ST_SUM;
            end
          end
        end
        ST_ANA: begin
          // Two bytes per enabled channel, MSB first
          if (step) begin
            lowHalf_reg <= ~lowHalf_reg;
            if (lowHalf_reg) begin
              pending_reg[chan] <= 1'b0;
              if ((pending_reg & ~(8'h01 << chan)) == 8'h00) begin
                state_reg <= ST_SUM;
              end
            end
          end
        end
        ST_SUM: begin
          if (step) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered output byte; content follows the current position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txData <= 8'h00;
      txValid <= 1'b0;
    end else begin
      txValid <= 1'b0;
      txData <= 8'h00;
      case (state_reg)
        ST_HEAD: begin
          txValid <= ~step;
          txData <= headByte;
        end
        ST_DIG: begin
          txValid <= ~step;
          txData <= lowHalf_reg ? dSamp_reg[7:0] : dSamp_reg[15:8];
        end
        ST_ANA: begin
          txValid <= ~step && found;
          txData <= lowHalf_reg ? anaWord[7:0] : anaWord[15:8];
        end
        ST_SUM: begin
          txValid <= ~step;
          txData <= checkSum;
        end
        default: begin
          txValid <= 1'b0;
        end
      endcase
    end
  end

  // Status pulses and busy flag back to the radio path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sampleTaken <= 1'b0;
      sampleDropped <= 1'b0;
      frameBusy <= 1'b0;
    end else begin
      sampleTaken <= accept;
      // Samples in transparent mode or with other options are dropped
      sampleDropped <= sampleValid && (state_reg == ST_IDLE)
                       && !accept;
      frameBusy <= (state_reg != ST_IDLE) || accept;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_start;
    txValid && txReady && state_reg == ST_HEAD && index_reg == 5'd0;
  endsequence

  a_gate_mode: assert property (sampleTaken
    |-> $past(apiOutputOption) == 1'b0 && $past(apiFramedMode))
    else $error("frame started outside framed option zero");

  a_start_byte: assert property (s_start |-> txData == `START_DELIM)
    else $error("first byte is not the delimiter");

  a_type_byte: assert property (state_reg == ST_HEAD && txValid
    && index_reg == 5'd3 |-> txData == `FRAME_TYPE_IO)
    else $error("frame type byte wrong");

  a_count_byte: assert property (state_reg == ST_HEAD && txValid
    && index_reg == 5'd15 |-> txData == `SAMPLE_SETS)
    else $error("sample set count not one");

  a_dig_skip: assert property (state_reg == ST_DIG
    |-> dMask_reg != 16'h0000)
    else $error("digital field sent with empty mask");

  a_dig_zero: assert property (state_reg == ST_DIG && txValid
    |-> (txData & ~(lowHalf_reg ? dMask_reg[7:0] : dMask_reg[15:8]))
    == 8'h00)
    else $error("disabled digital bit set");

  a_ana_order: assert property (state_reg == ST_ANA && found
    && chan == 3'h7 |-> pending_reg[3:0] == 4'h0)
    else $error("supply reading before inputs");

  a_len_value: assert property (state_reg == ST_SUM
    |-> sentCount_reg == length_reg)
    else $error("length differs from bytes sent");

  a_opts_value: assert property (state_reg == ST_HEAD && txValid
    && index_reg == 5'd14 |-> txData inside {8'h00, `OPT_ACKED, `OPT_BCAST})
    else $error("receive options byte invalid");
endmodule // io_sample_rx_frame_builder
`default_nettype wire

// [io_sample_rx_regs.svh]
// Purpose: constants for the received IO sample frame builder
// Assumes: one 40 MHz clock, byte-wide output stream
// Notes: offsets are byte positions within the emitted frame
`ifndef IO_SAMPLE_RX_REGS_SVH
`define IO_SAMPLE_RX_REGS_SVH

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define START_DELIM 8'h7E
`define FRAME_TYPE_IO 8'h92
`define SAMPLE_SETS 8'h01
`define OPT_ACKED 8'h01
`define OPT_BCAST 8'h02
`define API_OPT_FRAMED 1'b0
`define OFS_TYPE 5'h03
`define OFS_OPTS 5'h0E
`define OFS_AMASK 5'h12
// Fixed bytes from type to analog mask, inclusive
`define FIXED_LEN 16'h0010
// Masks of lines that can exist
`define DMASK_VALID 16'h1CFF
`define AMASK_VALID 8'h8F
`define AMASK_SUPPLY 3'h7

`endif

// [io_sample_rx_pkg.sv]
// Purpose: types for the received IO sample frame builder
// Assumes: nothing beyond the constants header
// Notes: state codes are one-hot
package io_sample_rx_pkg;

  // --------------------------------------------------------------
  // Emitter states
  // --------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_HEAD = 6'h02,
    ST_DIG = 6'h04,
    ST_ANA = 6'h08,
    ST_SUM = 6'h10,
    ST_DONE = 6'h20
  } emit_state_t;

  typedef logic [7:0] byte_t;

endpackage

// [io_checksum_acc.sv]
// Purpose: running byte sum and checksum for the emitted frame
// Assumes: clear and add never coincide in a meaningful frame
// Notes: checksum is FF minus low eight bits of the sum
`timescale 1ns/10ps
`default_nettype none
module io_checksum_acc (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] dataIn,
  // Result
  output logic [7:0] checkSum
);
  logic [7:0] sum_reg;

  // Accumulate low eight bits only, carries are dropped on purpose
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg <= 8'h00;
    end else if (clear) begin
      sum_reg <= 8'h00;
    end else if (add) begin
      sum_reg <= sum_reg + dataIn;
    end
  end

  assign checkSum = 8'hFF - sum_reg;
endmodule // io_checksum_acc
`default_nettype wire

// [io_analog_pick.sv]
// Purpose: finds the next enabled analog channel in frame order
// Assumes: channel indices 0..3 are inputs, 7 is supply voltage
// Notes: pure combinational priority pick
`timescale 1ns/10ps
`default_nettype none
module io_analog_pick (
  // Remaining channels
  input wire logic [7:0] pending,
  // Selection
  output logic found,
  output logic [2:0] chan
);
  // Lowest input first, supply reading last
  always_comb begin
    found = 1'b1;
    if (pending[0]) begin
      chan = 3'h0;
    end else if (pending[1]) begin
      chan = 3'h1;
    end else if (pending[2]) begin
      chan = 3'h2;
    end else if (pending[3]) begin
      chan = 3'h3;
    end else if (pending[7]) begin
      chan = 3'h7;
    end else begin
      found = 1'b0;
      chan = 3'h0;
    end
  end
endmodule // io_analog_pick
`default_nettype wire

// [host_rx_model.sv]
// Purpose: host side that accepts the emitted frame byte stream
// Assumes: a byte moves when txValid and txReady meet at a rising edge
// Notes: slow mode offers ready one cycle in three to stretch frames
`timescale 1ns/10ps
`default_nettype none
module host_rx_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pacing
  input wire logic slowMode,
  // Byte stream
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  // ----------------------------------------------------------------
  // Accepted bytes, read by the bench
  // ----------------------------------------------------------------
  logic [7:0] rxQ[$];
  int paceCnt = 0;

  // Ready moves at the falling edge so it never races the sampling edge
  always @(negedge clock) begin
    paceCnt = paceCnt + 1;
    txReady <= rst_n && (!slowMode || paceCnt % 3 == 0);
  end

  // Bytes are kept whole so the checksum can be verified later
  always @(posedge clock) begin
    if (rst_n && txValid === 1'b1 && txReady === 1'b1) begin
      rxQ.push_back(txData);
    end
  end
endmodule // host_rx_model
`default_nettype wire

// [test_io_sample_rx_frame_builder.sv]
// Purpose: self-checking bench for the IO sample frame builder
// Assumes: inputs change at the falling edge, outputs are registered
// Notes: expected frames are built from integers and queues
`timescale 1ns/10ps
`default_nettype none
module test_io_sample_rx_frame_builder;
  import io_sample_rx_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic apiOutputOption = 1'b0;
  logic apiFramedMode = 1'b1;
  logic sampleValid = 1'b0;
  logic [63:0] srcLongAddr = 64'h0;
  logic [15:0] srcNetAddr = 16'h0;
  logic wasAcked = 1'b0;
  logic wasBroadcast = 1'b0;
  logic [15:0] digitalMask = 16'h0;
  logic [7:0] analogMask = 8'h0;
  logic [15:0] digitalSamples = 16'h0;
  logic [15:0] ana[5] = '{5{16'h0}};
  logic slowMode = 1'b0;
  logic sampleTaken, sampleDropped, txValid, txReady, frameBusy;
  byte_t txData;
  int bad_count = 0;
  int checks = 0;
  int seed = 72828;
  logic [7:0] expQ[$];

  // 40 MHz clock
  always #12.5 clock = ~clock;

  io_sample_rx_frame_builder i_io_sample_rx_frame_builder (
    .clock(clock), .rst_n(rst_n),
    .apiOutputOption(apiOutputOption), .apiFramedMode(apiFramedMode),
    .sampleValid(sampleValid), .srcLongAddr(srcLongAddr),
    .srcNetAddr(srcNetAddr), .wasAcked(wasAcked),
    .wasBroadcast(wasBroadcast), .digitalMask(digitalMask),
    .analogMask(analogMask), .digitalSamples(digitalSamples),
    .analogIn0(ana[0]), .analogIn1(ana[1]), .analogIn2(ana[2]),
    .analogIn3(ana[3]), .supplyVoltage(ana[4]),
    .sampleTaken(sampleTaken), .sampleDropped(sampleDropped),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .frameBusy(frameBusy)
  );

  host_rx_model i_host_rx_model (
    .clock(clock), .rst_n(rst_n), .slowMode(slowMode),
    .txData(txData), .txValid(txValid), .txReady(txReady)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put16(input logic [15:0] w);
    expQ.push_back(w[15:8]);
    expQ.push_back(w[7:0]);
  endtask

  // Reference frame from the current sample fields
  task automatic build_exp();
    logic [15:0] dm;
    logic [7:0] am;
    logic [7:0] sum;
    logic [15:0] len;
    int chan[5] = '{0, 1, 2, 3, 7};
    dm = digitalMask & 16'h1CFF;
    am = analogMask & 8'h8F;
    expQ = {8'h92};
    for (int i = 3; i >= 0; i--) put16(srcLongAddr[16*i +: 16]);
    put16(srcNetAddr);
    expQ.push_back(wasBroadcast ? 8'h02 : {7'h0, wasAcked});
    expQ.push_back(8'h01);
    put16(dm);
    expQ.push_back(am);
    if (dm != 16'h0) put16(digitalSamples & dm);
    foreach (chan[k]) if (am[chan[k]]) put16(ana[k]);
    sum = 8'h0;
    foreach (expQ[k]) sum += expQ[k];
    len = 16'(expQ.size());
    expQ.push_back(8'hFF - sum);
    expQ.push_front(len[7:0]);
    expQ.push_front(len[15:8]);
    expQ.push_front(8'h7E);
  endtask

  // One accepted sample, its frame collected by the host and compared
  task automatic run_frame(input logic [15:0] dm, input logic [7:0] am);
    int n;
    srcLongAddr = {$random(seed), $random(seed)};
    srcNetAddr = 16'($random(seed));
    {wasAcked, wasBroadcast, slowMode} = 3'($random(seed));
    digitalMask = dm;
    analogMask = am;
    digitalSamples = 16'($random(seed));
    foreach (ana[k]) ana[k] = 16'($random(seed));
    build_exp();
    sampleValid = 1'b1;
    n = 0;
    while (sampleTaken !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    sampleValid = 1'b0;
    check(16'(n < 20), 16'h1);
    n = 0;
    while (frameBusy !== 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check(16'(n < 2000), 16'h1);
    // Idle spacing before the host queue is compared and the next sample comes
    repeat (3) @(negedge clock);
    check(16'(i_host_rx_model.rxQ.size()), 16'(expQ.size()));
    foreach (expQ[k]) check(i_host_rx_model.rxQ[k], expQ[k]);
    i_host_rx_model.rxQ.delete();
  endtask

  // A sample offered in a wrong mode is dropped and sends nothing
  task automatic refuse(input logic opt, input logic framed);
    int drops;
    int sent;
    apiOutputOption = opt;
    apiFramedMode = framed;
    sampleValid = 1'b1;
    drops = 0;
    sent = 0;
    repeat (6) begin
      @(negedge clock);
      drops += (sampleDropped === 1'b1);
      sent += (txValid !== 1'b0 || frameBusy !== 1'b0);
    end
    sampleValid = 1'b0;
    apiOutputOption = 1'b0;
    apiFramedMode = 1'b1;
    check(16'(drops != 0), 16'h1);
    check(16'(sent), 16'h0);
    @(negedge clock);
  endtask

  // Reset in mid-frame empties the stream; the next frame must be whole
  task automatic reset_mid_frame();
    sampleValid = 1'b1;
    repeat (6) @(negedge clock);
    sampleValid = 1'b0;
    check(16'(frameBusy), 16'h1);
    rst_n = 1'b0;
    @(negedge clock);
    check(16'({txValid, frameBusy, sampleTaken}), 16'h0);
    rst_n = 1'b1;
    i_host_rx_model.rxQ.delete();
    @(negedge clock);
  endtask

  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    refuse(1'b1, 1'b1);
    refuse(1'b0, 1'b0);
    refuse(1'b1, 1'b0);
    run_frame(16'h001C, 8'h02);
    run_frame(16'h0000, 8'h00);
    run_frame(16'hFFFF, 8'hFF);
    run_frame(16'h1CFF, 8'h80);
    run_frame(16'h0400, 8'h09);
    reset_mid_frame();
    repeat (12) run_frame(16'($random(seed)), 8'($random(seed)));
    complete_run();
  end

  // Watchdog far beyond the longest run of slow frames
  initial begin
    #500000;
    bad_count++;
    complete_run();
  end
endmodule // test_io_sample_rx_frame_builder
`default_nettype wire
